// ===== include/wus_link_if.sv
// waveform uart streamer: link between device and receiver
`timescale 1ns/1ps
`default_nettype none
interface wus_link_if;
   logic txd;
   logic stream_err;
   modport dev (output txd, output stream_err);
   modport host (input txd, input stream_err);
endinterface
`default_nettype wire

// ===== include/wus_pkg.sv
// waveform uart streamer: shared constants, types and helper functions
// Contract
// [R1] config bits 4:1 select the link bit rate
// [R2] config bits 6:5 pick raw or compensated samples
// [R3] one sample per enabled channel at 4 kHz
// [R4] fixed channel order phase a v to auxiliary_input_5
// [R5] per-channel enable bits, phase a voltage at bit 7
// [R6] disabled channels skipped, no gaps in stream
// [R7] word is 24-bit value over 8-bit id
// [R8] values clamped to plus or minus 8388607
// [R9] four bytes per word, id byte first
// [R10] twelve channels need at least 3072000 baud
// [R11] minimum baud per enabled channel count
// [R12] too-slow config write raises the error indication
// [R13] samples dropped rather than stalling sampling
// [R14] receiver aligns on ids 0,1,2,3 four bytes apart
// [R15] software should prefer 3072 kbps
// [R16] id is position in fixed order
// [R17] 8n1 framing, line idles high
`default_nettype none
package wus_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   // sample period as a time, then in cycles
   localparam int SAMPLE_PERIOD_US = 250;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * CLK_MHZ;
   localparam int NCH = 12;
   localparam int CH_W = 4;
   localparam logic [CH_W-1:0] CH_FIRST = 4'h0;
   localparam logic [CH_W-1:0] CH_NONE = 4'hC;
   localparam int IN_W = 28;
   localparam int VAL_W = 24;
   localparam int ID_W = 8;
   localparam int WORD_W = 32;
   localparam int BYTE_W = 8;
   localparam logic [1:0] BYTE_FIRST = 2'h0;
   localparam logic [1:0] BYTE_LAST = 2'h3;
   localparam logic signed [IN_W-1:0] SAT_HI = 28'sh07F_FFFF;
   localparam logic signed [IN_W-1:0] SAT_LO = -SAT_HI;
   localparam int FRAME_BITS = 10;
   localparam int DIV_W = 8;
   // register bus
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CONFIG = 12'h000;
   localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] REG_MASK = 12'h008;
   localparam logic [ADDR_W-1:0] REG_STATE = 12'h00C;
   localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
   localparam int CFG_BAUD_LSB = 1;
   localparam int CFG_BAUD_W = 4;
   localparam int CFG_SRC_LSB = 5;
   localparam int CFG_SRC_W = 2;
   localparam int CFG_EN_LSB = 7;
   localparam logic [CFG_SRC_W-1:0] SRC_COMP = 2'h1;
   // status and mask bits
   localparam int ST_W = 3;
   localparam int ST_BAUD_ERR = 0;
   localparam int ST_DROP = 1;
   localparam int ST_SENT = 2;
   // receiver alignment: ids 1..3 must follow the id 0 word
   localparam logic [ID_W-1:0] ID_SYNC = 8'h00;
   localparam logic [1:0] SYNC_CHECKS_LAST = 2'h2;

   typedef logic [NCH-1:0][IN_W-1:0] wus_sample_arr_t;

   // bit rate for each baud code; codes above 5 fall back to a slow rate
   function automatic int baud_rate(input logic [CFG_BAUD_W-1:0] code);
      case (code)
         4'h0: return 256_000;
         4'h1: return 512_000;
         4'h2: return 1_024_000;
         4'h3: return 1_536_000;
         4'h4: return 2_048_000;
         4'h5: return 3_072_000;
         default: return 115_200;
      endcase
   endfunction

   // clock cycles per bit, rounded to nearest
   function automatic logic [DIV_W-1:0] clk_div(input logic [CFG_BAUD_W-1:0] code);
      int r;
      r = baud_rate(code);
      return DIV_W'((CLK_HZ + r / 2) / r);
   endfunction

   function automatic logic [CH_W-1:0] ones(input logic [NCH-1:0] v);
      logic [CH_W-1:0] n;
      n = '0;
      for (int i = 0; i < NCH; i++) begin
         n = n + CH_W'(v[i]);
      end
      return n;
   endfunction

   // least bit rate that carries n channels
   function automatic int min_baud(input logic [CH_W-1:0] n);
      if (n == 4'hC) return 3_072_000;
      if (n >= 4'h9) return 2_048_000;
      if (n >= 4'h6) return 1_536_000;
      if (n >= 4'h3) return 1_024_000;
      if (n == 4'h2) return 512_000;
      if (n == 4'h1) return 256_000;
      return 0;
   endfunction
endpackage
`default_nettype wire

// ===== src/wus_rx_host.sv
// waveform uart streamer, receiving end: 8n1 receiver and word aligner
`timescale 1ns/1ps
`default_nettype none
module wus_rx_host (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [wus_pkg::CFG_BAUD_W-1:0] baud_sel,
   wus_link_if.host link,
   output logic [wus_pkg::WORD_W-1:0] rx_word,
   output logic rx_valid,
   output logic aligned,
   output logic frame_err,
   output logic link_err
);
   import wus_pkg::*;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } wus_rx_state_t;

   wus_rx_state_t st_q;
   logic rx_s1_q, rx_s2_q, rx_s3_q, err_s1_q, err_s2_q;
   logic [DIV_W-1:0] tmr_q;
   logic [CH_W-1:0] bits_q;
   logic [BYTE_W-1:0] sr_q;
   logic [WORD_W-1:0] word_q;
   logic [1:0] pos_q, chk_q;
   logic hunt_q, aligned_q, valid_q, ferr_q;

   wire logic [DIV_W-1:0] div = clk_div(baud_sel);
   wire logic tmr_end = (tmr_q == '0);
   wire logic got_byte = (st_q == RX_STOP) && tmr_end && rx_s2_q;
   wire logic bad_stop = (st_q == RX_STOP) && tmr_end && !rx_s2_q;
   wire logic [ID_W-1:0] want_id = ID_W'(chk_q) + 1'b1;
   wire logic new_word = got_byte && !hunt_q && (pos_q == BYTE_FIRST);
   wire logic id_bad = new_word && !aligned_q && (sr_q != want_id); // R14
   wire logic restart = got_byte && (hunt_q || id_bad) && (sr_q == ID_SYNC);

   // pin synchronisers; the second stage is sampled, the third only serves start-edge detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
         err_s1_q <= 1'b0;
         err_s2_q <= 1'b0;
      end else begin
         rx_s1_q <= link.txd;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
         err_s1_q <= link.stream_err;
         err_s2_q <= err_s1_q;
      end
   end

   // bit receiver: start sampled mid bit, then one bit time per bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= RX_IDLE;
         tmr_q <= '0;
         bits_q <= '0;
         sr_q <= '0;
      end else begin
         tmr_q <= tmr_q - 1'b1;
         unique case (st_q)
            RX_IDLE: begin
               if (rx_s3_q && !rx_s2_q) begin
                  st_q <= RX_START;
                  tmr_q <= div >> 1;
               end
            end
            RX_START: begin
               if (tmr_end) begin
                  st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
                  tmr_q <= div - 1'b1;
                  bits_q <= CH_W'(BYTE_W - 1);
               end
            end
            RX_DATA: begin
               if (tmr_end) begin
                  sr_q <= {rx_s2_q, sr_q[BYTE_W-1:1]}; // R17
                  tmr_q <= div - 1'b1;
                  bits_q <= bits_q - 1'b1;
                  if (bits_q == '0) begin
                     st_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (tmr_end) begin
                  st_q <= RX_IDLE;
               end
            end
            default: st_q <= RX_IDLE;
         endcase
      end
   end

   // word aligner: hunt for id 0, then confirm ids 1, 2, 3 a word apart
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hunt_q <= 1'b1;
         aligned_q <= 1'b0;
         pos_q <= BYTE_FIRST;
         chk_q <= '0;
         word_q <= '0;
         valid_q <= 1'b0;
         ferr_q <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         ferr_q <= bad_stop;
         if (bad_stop) begin
            hunt_q <= 1'b1;
            aligned_q <= 1'b0;
         end else if (restart) begin
            hunt_q <= 1'b0; // R14
            pos_q <= BYTE_FIRST + 1'b1;
            chk_q <= '0;
            word_q <= {sr_q, word_q[WORD_W-1:BYTE_W]};
         end else if (id_bad || (got_byte && hunt_q)) begin
            hunt_q <= 1'b1; // R14
         end else if (got_byte) begin
            word_q <= {sr_q, word_q[WORD_W-1:BYTE_W]}; // R9
            pos_q <= pos_q + 1'b1;
            if (new_word && !aligned_q) begin
               chk_q <= chk_q + 1'b1;
               aligned_q <= (chk_q == SYNC_CHECKS_LAST);
            end
            valid_q <= aligned_q && (pos_q == BYTE_LAST);
         end
      end
   end

   assign rx_word = word_q;
   assign rx_valid = valid_q;
   assign aligned = aligned_q;
   assign frame_err = ferr_q;
   assign link_err = err_s2_q;
endmodule
`default_nettype wire

// ===== src/wus_streamer.sv
// waveform uart streamer, device end: sampler, framer and apb register slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module wus_streamer #(
   parameter int SAMPLE_CYCLES = wus_pkg::SAMPLE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wus_pkg::ADDR_W-1:0] paddr,
   input wire logic [wus_pkg::DATA_W-1:0] pwdata,
   output logic [wus_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire wus_pkg::wus_sample_arr_t raw_samples,
   input wire wus_pkg::wus_sample_arr_t comp_samples,
   output logic irq,
   wus_link_if.dev link
);
   import wus_pkg::*;
   localparam int TMR_W = $clog2(SAMPLE_CYCLES);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SAMPLE_CYCLES - 1);

   // first enabled channel at or after a start position in the fixed order
   function automatic logic [CH_W-1:0] next_en(input logic [NCH-1:0] en, input logic [CH_W-1:0] from);
      logic [CH_W-1:0] r;
      r = CH_NONE;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (en[i] && (CH_W'(i) >= from)) begin
            r = CH_W'(i);
         end
      end
      return r;
   endfunction

   // symmetric clamp, so the most negative 24-bit code never appears
   function automatic logic [VAL_W-1:0] saturate(input logic signed [IN_W-1:0] v);
      logic [VAL_W-1:0] r;
      r = v[VAL_W-1:0];
      if (v > SAT_HI) begin
         r = SAT_HI[VAL_W-1:0];
      end else if (v < SAT_LO) begin
         r = SAT_LO[VAL_W-1:0];
      end
      return r;
   endfunction

   logic [DATA_W-1:0] cfg_q;
   logic [DATA_W-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic err_q;
   logic [ST_W-1:0] sts_q;
   logic [ST_W-1:0] sts_d;
   logic [ST_W-1:0] mask_q;
   logic [TMR_W-1:0] tmr_q;
   logic busy_q;
   logic [CH_W-1:0] ch_q;
   logic [1:0] byte_q;
   logic [NCH-1:0] en_q;
   logic [VAL_W-1:0] snap_q [NCH];
   logic tx_ready;

   // apb phases: answer one cycle into the access phase
   wire logic acc = psel && penable && !pready_q;
   wire logic done = psel && penable && pready_q;
   wire logic wr = done && pwrite;
   wire logic hit_cfg = (paddr == REG_CONFIG);
   wire logic hit_sts = (paddr == REG_STATUS);
   wire logic hit_mask = (paddr == REG_MASK);
   wire logic hit_state = (paddr == REG_STATE);
   wire logic hit = hit_cfg || hit_sts || hit_mask || hit_state;

   // live configuration fields
   wire logic [CFG_BAUD_W-1:0] baud_sel = cfg_q[CFG_BAUD_LSB +: CFG_BAUD_W]; // R1
   wire logic [CFG_SRC_W-1:0] src_sel = cfg_q[CFG_SRC_LSB +: CFG_SRC_W];
   wire logic [NCH-1:0] en_live = cfg_q[CFG_EN_LSB +: NCH]; // R5
   wire logic use_comp = (src_sel == SRC_COMP); // R2
   wire logic [DIV_W-1:0] bit_div = clk_div(baud_sel); // R1

   // rate check on the value being written, not the stored one
   wire logic [NCH-1:0] wr_en = pwdata[CFG_EN_LSB +: NCH];
   wire logic [CFG_BAUD_W-1:0] wr_baud = pwdata[CFG_BAUD_LSB +: CFG_BAUD_W];
   wire logic cfg_wr = wr && hit_cfg;
   wire logic bad_cfg = baud_rate(wr_baud) < min_baud(ones(wr_en)); // R11

   // sample period timing and frame walk
   wire logic tick = (tmr_q == '0); // R3
   wire logic [CH_W-1:0] first_ch = next_en(en_live, CH_FIRST);
   wire logic start = tick && !busy_q && (first_ch != CH_NONE);
   wire logic drop = tick && busy_q; // R13
   wire logic take = busy_q && tx_ready;
   wire logic last_byte = (byte_q == BYTE_LAST);
   wire logic [CH_W-1:0] nxt_ch = next_en(en_q, ch_q + 1'b1); // R6
   wire logic frame_end = take && last_byte && (nxt_ch == CH_NONE);
   wire logic [WORD_W-1:0] tx_word = {snap_q[ch_q], ID_W'(ch_q)}; // R7 R16
   wire logic [BYTE_W-1:0] tx_byte = tx_word[{byte_q, 3'b000} +: BYTE_W]; // R9

   wire logic [ST_W-1:0] ev = {frame_end, drop, cfg_wr && bad_cfg}; // R12
   wire logic [ST_W-1:0] clr = (wr && hit_sts) ? pwdata[ST_W-1:0] : '0;
   wire logic [DATA_W-1:0] state_word = DATA_W'({err_q, busy_q, ones(en_live)});
   wire logic [DATA_W-1:0] rdata = hit_cfg ? cfg_q :
                                   hit_sts ? DATA_W'(sts_q) :
                                   hit_mask ? DATA_W'(mask_q) :
                                   hit_state ? state_word : '0;

   // a new event wins over a clear in the same cycle
   assign sts_d = (sts_q & ~clr) | ev;

   // bus answer registers; unmapped addresses answer with an error
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !hit;
         if (acc) begin
            prdata_q <= rdata;
         end
      end
   end

   // software registers, written only at the completing edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= CFG_RESET;
         mask_q <= '0;
      end else if (wr && hit_cfg) begin
         cfg_q <= pwdata;
      end else if (wr && hit_mask) begin
         mask_q <= pwdata[ST_W-1:0];
      end
   end

   // error pin follows the last configuration write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         err_q <= 1'b0;
      end else if (cfg_wr) begin
         err_q <= bad_cfg; // R12
      end
   end

   // sticky status and level interrupt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sts_q <= '0;
         irq_q <= 1'b0;
      end else begin
         sts_q <= sts_d;
         irq_q <= |(sts_d & mask_q);
      end
   end

   // free running 4 khz period timer; never stalled by the link
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tmr_q <= TMR_LAST;
      end else if (tick) begin
         tmr_q <= TMR_LAST;
      end else begin
         tmr_q <= tmr_q - 1'b1;
      end
   end

   // frame walk; a period that finds the link busy is skipped whole
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'b0;
         ch_q <= CH_FIRST;
         byte_q <= BYTE_FIRST;
         en_q <= '0;
      end else if (start) begin
         busy_q <= 1'b1;
         ch_q <= first_ch; // R4
         byte_q <= BYTE_FIRST;
         en_q <= en_live;
      end else if (take) begin
         byte_q <= byte_q + 1'b1;
         if (last_byte) begin
            ch_q <= nxt_ch; // R6
            busy_q <= (nxt_ch != CH_NONE);
         end
      end
   end

   // per channel snapshot, so a frame is coherent while it drains
   for (genvar c = 0; c < NCH; c++) begin : g_snap
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            snap_q[c] <= '0;
         end else if (start) begin
            snap_q[c] <= saturate(use_comp ? comp_samples[c] : raw_samples[c]); // R8
         end
      end
   end

   // serialiser; its line output is a flip-flop
   wus_uart_tx u_tx (
      .clk(clk),
      .resetn(resetn),
      .bit_div(bit_div),
      .tx_byte(tx_byte),
      .tx_valid(busy_q),
      .tx_ready(tx_ready),
      .txd(link.txd)
   );

   assign link.stream_err = err_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// ===== src/wus_uart_tx.sv
// waveform uart streamer: byte serialiser, 8n1
`timescale 1ns/1ps
`default_nettype none
module wus_uart_tx (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [wus_pkg::DIV_W-1:0] bit_div,
   input wire logic [wus_pkg::BYTE_W-1:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic txd
);
   import wus_pkg::*;
   logic [FRAME_BITS-1:0] shift_q;
   logic [CH_W-1:0] cnt_q;
   logic [DIV_W-1:0] tmr_q;
   logic busy_q;

   wire logic bit_end = busy_q && (tmr_q == '0);
   // the last bit end frees the shifter, so the next byte follows its stop bit with no idle cycle
   wire logic last_end = bit_end && (cnt_q == '0);
   wire logic can_load = !busy_q || last_end;
   wire logic load = tx_valid && can_load;
   wire logic [DIV_W-1:0] tmr_top = bit_div - 1'b1;

   // shifter: start bit, data lsb first, stop bit; all ones when idle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shift_q <= '1;
         busy_q <= 1'b0;
         cnt_q <= '0;
         tmr_q <= '0;
      end else if (load) begin
         shift_q <= {1'b1, tx_byte, 1'b0}; // R17
         busy_q <= 1'b1;
         cnt_q <= CH_W'(FRAME_BITS - 1);
         tmr_q <= tmr_top;
      end else if (bit_end) begin
         shift_q <= {1'b1, shift_q[FRAME_BITS-1:1]};
         tmr_q <= tmr_top;
         busy_q <= (cnt_q != '0);
         cnt_q <= cnt_q - 1'b1;
      end else if (busy_q) begin
         tmr_q <= tmr_q - 1'b1;
      end
   end

   assign txd = shift_q[0];
   assign tx_ready = can_load;
endmodule
`default_nettype wire

// ===== test/tb.sv
// testbench: streamer and receiver over one link, apb stimulus, word scoreboard
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wus_pkg::*;
   localparam int SC = 4000;
   localparam int DIV = 8;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, irq, rx_valid, aligned, frame_err, link_err;
   logic [WORD_W-1:0] rx_word;
   wus_sample_arr_t raw = '0;
   wus_sample_arr_t comp = '0;
   logic [CFG_BAUD_W-1:0] baud_sel = 4'h5;
   logic [WORD_W-1:0] exp_q[$];
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   wus_link_if link();
   wus_streamer #(.SAMPLE_CYCLES(SC)) u_wus_streamer(.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .raw_samples(raw), .comp_samples(comp), .irq(irq), .link(link));
   wus_rx_host u_wus_rx_host(.clk(clk), .resetn(resetn), .baud_sel(baud_sel), .link(link), .rx_word(rx_word),
      .rx_valid(rx_valid), .aligned(aligned), .frame_err(frame_err), .link_err(link_err));
   wus_link_props #(.DIV(DIV), .SC(SC)) u_wus_link_props(.clk(clk), .resetn(resetn), .txd(link.txd),
      .stream_err(link.stream_err));
   always #20 clk = ~clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d of %0d compares", fails, n_compared);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one apb transfer; waits on pready with no timeout of its own, the hang guard bounds a hang
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic exp_err);
      logic [DATA_W-1:0] r;
      logic e;
      apb(1'b0, a, '0, r, e);
      check(r, exp);
      check(32'(e), 32'(exp_err));
   endtask
   function automatic int rate(input int c);
      int t[6] = '{256000, 512000, 1024000, 1536000, 2048000, 3072000};
      return c < 6 ? t[c] : 115200;
   endfunction
   function automatic int min_rate(input int n);
      return n == 12 ? 3072000 : n >= 9 ? 2048000 : n >= 6 ? 1536000 : n >= 3 ? 1024000 : n == 2 ? 512000 :
         n == 1 ? 256000 : 0;
   endfunction
   function automatic logic [23:0] clampv(input logic signed [27:0] v);
      if (v > 28'sh07F_FFFF) return 24'h7F_FFFF;
      if (v < -28'sh07F_FFFF) return 24'h80_0001;
      return v[23:0];
   endfunction
   function automatic logic [31:0] cfg(input logic [3:0] code, input logic [1:0] src, input logic [11:0] en);
      return {13'h0000, en, src, code, 1'b0};
   endfunction
   // scoreboard: every received word takes the oldest expectation
   always @(posedge clk) begin
      if (rx_valid === 1'b1 && exp_q.size() == 0) begin
         fails++;
         $display("unexpected at %0t: extra word %h", $time, rx_word);
      end else if (rx_valid === 1'b1) check(rx_word, exp_q.pop_front());
      if (frame_err !== 1'b0) check(32'(frame_err), 32'h0000_0000);
   end
   // hang guard, well above five sample periods
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      logic [31:0] r;
      logic [11:0] en;
      logic [1:0] src;
      logic signed [27:0] v;
      r = $urandom(2);
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rdchk(REG_CONFIG, CFG_RESET, 1'b0);
      rdchk(12'h010, 32'h0000_0000, 1'b1);
      wr(REG_MASK, 32'h0000_0001);
      rdchk(REG_MASK, 32'h0000_0001, 1'b0);
      // every baud code against a channel count, all before the first tick
      for (int i = 0; i < 16; i++) begin
         en = (i == 5 || i == 15) ? 12'hFFF : 12'($urandom);
         wr(REG_CONFIG, cfg(4'(i), 2'h0, en));
         rdchk(REG_STATE, {26'h0, rate(i) < min_rate($countones(en)), 1'b0, 4'($countones(en))}, 1'b0);
      end
      wr(REG_STATUS, 32'h0000_0007);
      wr(REG_CONFIG, cfg(4'h4, 2'h0, 12'hFFF));
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0000_0001);
      wr(REG_MASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0000_0000);
      check(32'(link_err), 32'h0000_0001);
      wr(REG_MASK, 32'h0000_0001);
      wr(REG_STATUS, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0000_0000);
      // frames; the first one spends ids 0 to 2 on receiver alignment, id 3 completes it and is delivered
      for (int f = 0; f < 5; f++) begin
         en = 12'($urandom) | 12'h03F;
         src = 2'(f);
         for (int c = 0; c < NCH; c++) begin
            v = 28'($urandom) >>> ($urandom % 8);
            // extremes on the raw path; source code 10 streams raw
            if (f == 2 && c == 4) v = 28'sh800_0000;
            if (f == 2 && c == 5) v = 28'shF80_0000;
            raw[c] <= v;
            comp[c] <= ~v;
            if (en[c] && !(f == 0 && c < 3)) exp_q.push_back({clampv(src == 2'h1 ? ~v : v), 8'(c)});
         end
         wr(REG_CONFIG, cfg(4'h5, src, en));
         for (int t = 0; t < 2 * SC && exp_q.size() > 0; t++) @(posedge clk);
         check(32'(exp_q.size()), 32'h0000_0000);
         check(32'(aligned), 32'h0000_0001);
         check(32'(link_err), 32'h0000_0000);
      end
      // only the frame-sent bit: no dropped period, no rate error after the clear
      rdchk(REG_STATUS, 32'h0000_0004, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire

// ===== test/wus_link_props.sv
// waveform uart streamer: assertions on the link line
`timescale 1ns/1ps
`default_nettype none
module wus_link_props #(
   parameter int DIV = 8,
   parameter int SC = 4000
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic txd,
   input wire logic stream_err
);
   int cnt, gap, since;
   logic busy, firstw, seen, fst, endb;
   logic [1:0] bidx;
   logic [7:0] sh, last_id;
   logic [15:0] lo16;
   logic [3:0] bitpos;
   // a frame begins after the line idles longer than one byte time
   assign fst = !busy && !txd && gap > 10 * DIV;
   assign endb = busy && cnt == 10 * DIV - 1;
   assign bitpos = 4'(cnt / DIV);
   // byte tracker; the start cycle of a byte is seen with busy low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
         gap <= 0;
         since <= 0;
         busy <= 1'b0;
         firstw <= 1'b0;
         seen <= 1'b0;
         bidx <= 2'h0;
         sh <= 8'h00;
         last_id <= 8'h00;
         lo16 <= 16'h0000;
      end else begin
         gap <= (busy || !txd) ? 0 : gap + 1;
         since <= fst ? 1 : since + 1;
         if (fst) seen <= 1'b1;
         if (!busy && !txd) begin
            busy <= 1'b1;
            cnt <= 1;
            if (fst) bidx <= 2'h0;
            if (fst) firstw <= 1'b1;
         end else if (busy) begin
            cnt <= endb ? 0 : cnt + 1;
            // mid-bit sample, data arrives lsb first
            if (cnt % DIV == DIV / 2 && bitpos >= 4'h1 && bitpos <= 4'h8) sh <= {txd, sh[7:1]};
            if (endb) begin
               busy <= 1'b0;
               bidx <= bidx + 2'h1;
               if (bidx == 2'h0) last_id <= sh;
               if (bidx == 2'h0) firstw <= 1'b0;
               if (bidx == 2'h1) lo16[7:0] <= sh;
               if (bidx == 2'h2) lo16[15:8] <= sh;
            end
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_byte_end;
      busy && cnt == 10 * DIV - 1;
   endsequence
   a_start_low: assert property (busy && bitpos == 4'h0 |-> !txd)
      else $error("start bit not low");
   a_start_len: assert property (fst |-> !txd [*8])
      else $error("short start bit");
   a_stop_high: assert property (busy && bitpos == 4'h9 |-> txd)
      else $error("stop bit not high");
   a_bit_steady: assert property (busy && cnt % DIV != 0 |-> $stable(txd))
      else $error("bit time broken");
   a_word_whole: assert property (s_byte_end ##0 bidx != 2'h3 |=> !txd)
      else $error("gap inside a word");
   a_id_order: assert property (s_byte_end ##0 bidx == 2'h0 |-> sh < 8'h0C && (firstw || sh > last_id))
      else $error("channel id out of order");
   a_value_clamp: assert property (s_byte_end ##0 bidx == 2'h3 |-> !(sh == 8'h80 && lo16 == 16'h0000))
      else $error("value not clamped");
   a_period_grid: assert property (fst && seen |-> since % SC == 0)
      else $error("frame off the sample grid");
   c_err_seen: cover property ($rose(stream_err));
endmodule
`default_nettype wire
